// ===== cis_exec.sv
// Instruction execution unit with dedicated registers and privilege checks
// Notes on behaviour
// - Integer operands come in byte, word or double word lengths.
// - Short operand is a 4-bit field inside the basic instruction.
// - Implied immediate is the 8-bit byte after all addressing extensions.
// - Displacements of 8, 16 or 32 bits are all accepted.
// - Dedicated register select: SP, static base, frame, vectors, status, low flags.
// - Condition code is a 4-bit field inside the basic instruction.
// - Quick load, sum and compare use a sign-extended 4-bit constant.
// - Block copy and compare work on 1 to 16 bytes given by displacement.
// - Zero or sign extension widens byte to word or double word.
// - Two divides: toward zero with remainder, floor with modulus.
// - Lsb invert flips only bit 0; full invert flips every bit.
// - Condition result stored as one or zero at operand length.
// - Strings use r4 compare, r3 table, r2 and r1 pointers, r0 limit.
// - Backward option decrements the string pointers each step.
// - Until stops on match with r4; while stops on mismatch.
// - Limit count r0 decrements each element; zero always ends the string.
// - Status bit set and clear are privileged unless byte length.
// - Dedicated load and store are privileged for status or vector registers.
// - Count-and-loop adds constant, stores, branches if result nonzero.
// - Carry add adds carry in; borrow subtract subtracts it.
// - Shifts and rotate go left or right by the count sign.
// - Field read extracts and aligns; field write inserts; short forms use immediates.
`include "cis_regs.svh"
module cis_exec (
   input logic clk,
   input logic rstn,
   input logic req_valid,
   input cis_pkg::cis_req_type req,
   output logic res_valid,
   output cis_pkg::cis_res_type res,
   output logic [15:0] proc_condition_reg
);
   import cis_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   logic rstn_meta_reg;
   logic rstn_sync_reg;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rstn_meta_reg <= 1'b0;
         rstn_sync_reg <= 1'b0;
      end else begin
         rstn_meta_reg <= 1'b1;
         rstn_sync_reg <= rstn_meta_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Displacement length is carried in the top bits of its first byte
   function automatic logic [31:0] disp_decode(logic [31:0] raw);
      if (!raw[31]) begin
         disp_decode = {{25{raw[30]}}, raw[30:24]};
      end else if (!raw[30]) begin
         disp_decode = {{18{raw[29]}}, raw[29:16]};
      end else begin
         disp_decode = {{2{raw[29]}}, raw[29:0]};
      end
   endfunction

   function automatic logic cond_eval(logic [3:0] cc, logic [15:0] p);
      logic z;
      logic n;
      logic l;
      z = p[`CIS_PSR_Z];
      n = p[`CIS_PSR_N];
      l = p[`CIS_PSR_L];
      case (cc)
         4'h0: cond_eval = z;
         4'h1: cond_eval = !z;
         4'h2: cond_eval = p[`CIS_PSR_C];
         4'h3: cond_eval = !p[`CIS_PSR_C];
         4'h4: cond_eval = l;
         4'h5: cond_eval = !l;
         4'h6: cond_eval = n;
         4'h7: cond_eval = !n;
         4'h8: cond_eval = p[`CIS_PSR_F];
         4'h9: cond_eval = !p[`CIS_PSR_F];
         4'hA: cond_eval = !(l || z);
         4'hB: cond_eval = l || z;
         4'hC: cond_eval = !(n || z);
         4'hD: cond_eval = n || z;
         4'hE: cond_eval = 1'b1;
         default: cond_eval = 1'b0;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Field and shift operands
   logic [7:0] imm_byte;
   logic [31:0] dsp;
   logic [31:0] fld_base;
   logic [4:0] fld_off;
   logic [5:0] fld_len;
   logic [31:0] bit_y;

   always_comb begin
      imm_byte = req.tail[{req.ext_len, 3'b000} +: 8];
      dsp = disp_decode(req.disp_raw);
      fld_base = req.src;
      fld_off = req.idx[4:0];
      fld_len = dsp[5:0];
      if (req.op == OP_SFREAD || req.op == OP_SFWRITE) begin
         fld_off = {2'b00, imm_byte[7:`CIS_SFLD_OFF_LSB]};
         fld_len = {1'b0, imm_byte[`CIS_SFLD_LEN_W-1:0]} + 6'h01;
      end
      if (req.op == OP_FWRITE || req.op == OP_SFWRITE || req.op == OP_LSH ||
          req.op == OP_ASH || req.op == OP_ROT) begin
         fld_base = req.dst;
      end
   end

   cis_bitops u_bitops (
      .op(req.op),
      .len(req.len),
      .count(req.src[7:0]),
      .base(fld_base),
      .field_write_align(req.src),
      .off(fld_off),
      .flen(fld_len),
      .y(bit_y)
   );

   ////////////////////////////////////////////////////////////////////////////
   cis_res_type res_reg;
   cis_res_type res_next;
   logic res_valid_reg;
   logic res_valid_next;
   logic [15:0] psr_reg;
   logic [15:0] psr_next;
   logic [31:0] sp_reg;
   logic [31:0] sp_next;
   logic [31:0] sb_reg;
   logic [31:0] sb_next;
   logic [31:0] fp_reg;
   logic [31:0] fp_next;
   logic [31:0] intb_reg;
   logic [31:0] intb_next;

   always_comb begin
      cis_res_type r;
      logic [3:0] sh;
      logic [31:0] s4;
      logic [31:0] a;
      logic [31:0] b;
      logic [31:0] opnd;
      logic [32:0] wide;
      logic signed [31:0] sa;
      logic signed [31:0] sd;
      logic signed [31:0] q;
      logic signed [31:0] rm;
      logic [31:0] step;
      logic [31:0] elem;
      logic stop;
      logic priv;
      logic [5:0] w;
      r = '0;
      psr_next = psr_reg;
      sp_next = sp_reg;
      sb_next = sb_reg;
      fp_next = fp_reg;
      intb_next = intb_reg;
      sh = req.field_write_align[`CIS_SHORT_LSB +: 4];
      s4 = {{28{sh[3]}}, sh};
      w = len_width(req.len);
      a = fit(req.src, req.len);
      b = fit(req.dst, req.len);
      opnd = (req.op == OP_QSUM || req.op == OP_QCMP) ? fit(s4, req.len) : a;
      wide = 33'h000000000;
      sa = sext(req.src, req.len);
      sd = sext(req.dst, req.len);
      q = 32'sh00000000;
      rm = 32'sh00000000;
      step = 32'(w >> 3);
      elem = 32'h00000000;
      stop = 1'b0;
      case (req.op)
         OP_MOVE: r.value = a;
         OP_QLOAD: r.value = fit(s4, req.len);
         OP_QSUM, OP_ADD, OP_CADD: begin
            wide = {1'b0, opnd} + {1'b0, b} + {32'h00000000, (req.op == OP_CADD) && psr_reg[`CIS_PSR_C]};
            r.value = fit(wide[31:0], req.len);
            psr_next[`CIS_PSR_C] = wide[w];
            psr_next[`CIS_PSR_F] = (opnd[w-1] == b[w-1]) && (r.value[w-1] != b[w-1]);
         end
         OP_SUB, OP_BSUB: begin
            wide = {1'b0, b} - {1'b0, a} - {32'h00000000, (req.op == OP_BSUB) && psr_reg[`CIS_PSR_C]};
            r.value = fit(wide[31:0], req.len);
            psr_next[`CIS_PSR_C] = wide[w];
            psr_next[`CIS_PSR_F] = (a[w-1] != b[w-1]) && (r.value[w-1] != b[w-1]);
         end
         OP_CMP, OP_QCMP: begin
            psr_next[`CIS_PSR_Z] = opnd == b;
            psr_next[`CIS_PSR_N] = $signed(sext(opnd, req.len)) > sd;
            psr_next[`CIS_PSR_L] = opnd > b;
         end
         OP_BCOPY, OP_BCMP: begin
            // Byte count outside 1 to 16 is refused as illegal
            if (dsp < `CIS_BLK_MIN || dsp > `CIS_BLK_MAX) begin
               r.trap_illegal = 1'b1;
            end else begin
               r.equal = 1'b1;
               for (int i = 0; i < `CIS_BLK_BYTES; i++) begin
                  r.blk[8*i +: 8] = (i < dsp) ? req.blk_a[8*i +: 8] : req.blk_b[8*i +: 8];
                  if (i < dsp && req.blk_a[8*i +: 8] != req.blk_b[8*i +: 8]) begin
                     r.equal = 1'b0;
                  end
               end
               if (req.op == OP_BCOPY) begin
                  r.blk = r.blk;
               end else begin
                  r.blk = '0;
                  psr_next[`CIS_PSR_Z] = r.equal;
               end
            end
         end
         OP_ZEXT: r.value = fit(a, req.dst_len);
         OP_SEXT: r.value = fit(sa, req.dst_len);
         OP_TZRAT, OP_TZRES, OP_FLRAT, OP_FLRES: begin
            if (sa == 32'sh00000000) begin
               r.trap_div = 1'b1;
            end else begin
               q = sd / sa;
               rm = sd % sa;
               if ((req.op == OP_FLRAT || req.op == OP_FLRES) && rm != 32'sh00000000 && (rm[31] != sa[31])) begin
                  q = q - 32'sh00000001;
                  rm = rm + sa;
               end
               r.value = fit((req.op == OP_TZRAT || req.op == OP_FLRAT) ? q : rm, req.len);
            end
         end
         OP_LSBINV: r.value = {a[31:1], ~a[0]};
         OP_ALLINV: r.value = fit(~a, req.len);
         OP_CBOOL: r.value = {31'h00000000, cond_eval(req.field_write_align[`CIS_COND_LSB +: 4], psr_reg)};
         OP_LSH, OP_ASH, OP_ROT: r.value = bit_y;
         OP_FREAD, OP_SFREAD, OP_FWRITE, OP_SFWRITE: r.value = fit(bit_y, req.len);
         OP_STRING: begin
            // r0 limit, r1 and r2 pointers, r3 table, r4 compare
            elem = fit(req.src, req.len);
            r.aux = req.r3 + {24'h000000, elem[7:0]};
            r.r0 = req.r0;
            r.r1 = req.r1;
            r.r2 = req.r2;
            stop = (req.r0 == 32'h00000000) ||
                   (req.until_opt && elem == fit(req.r4, req.len)) ||
                   (req.while_opt && elem != fit(req.r4, req.len));
            if (stop) begin
               r.done = 1'b1;
            end else begin
               r.r0 = req.r0 - 32'h00000001;
               r.done = r.r0 == 32'h00000000;
               r.r1 = req.backward ? req.r1 - step : req.r1 + step;
               r.r2 = req.backward ? req.r2 - step : req.r2 + step;
            end
         end
         OP_ACB: begin
            r.value = fit(b + s4, req.len);
            r.branch = r.value != 32'h00000000;
            r.target = req.pc + dsp;
         end
         OP_LDREG: begin
            case (req.areg)
               AR_SP: sp_next = a;
               AR_SB: sb_next = a;
               AR_FP: fp_next = a;
               AR_INTB: intb_next = a;
               AR_PSR: psr_next = (req.len == LEN_B) ? {psr_reg[15:8], a[7:0]} : a[15:0];
               default: psr_next[`CIS_LOW_BYTE_W-1:0] = a[7:0];
            endcase
         end
         OP_STREG: begin
            case (req.areg)
               AR_SP: r.value = fit(sp_reg, req.len);
               AR_SB: r.value = fit(sb_reg, req.len);
               AR_FP: r.value = fit(fp_reg, req.len);
               AR_INTB: r.value = fit(intb_reg, req.len);
               AR_PSR: r.value = fit({16'h0000, psr_reg}, req.len);
               default: r.value = {24'h000000, psr_reg[7:0]};
            endcase
         end
         OP_BSET: psr_next = psr_reg | a[15:0];
         OP_BCLR: psr_next = psr_reg & ~a[15:0];
         OP_TRET, OP_IRET: begin
            psr_next = req.src[15:0];
            r.ret = 1'b1;
            r.target = req.pc + dsp;
         end
         default: r.value = 32'h00000000;
      endcase
      priv = (req.op == OP_TRET) || (req.op == OP_IRET) ||
             ((req.op == OP_BSET || req.op == OP_BCLR) && req.len != LEN_B) ||
             ((req.op == OP_LDREG || req.op == OP_STREG) &&
              (req.areg == AR_PSR || req.areg == AR_INTB));
      if ((priv && psr_reg[`CIS_PSR_U]) || !req_valid) begin
         // Trap suppresses every state change
         r = '0;
         r.trap_illegal = req_valid;
         psr_next = psr_reg;
         sp_next = sp_reg;
         sb_next = sb_reg;
         fp_next = fp_reg;
         intb_next = intb_reg;
      end
      res_next = req_valid ? r : res_reg;
      res_valid_next = req_valid;
   end

   always_ff @(posedge clk or negedge rstn_sync_reg) begin
      if (!rstn_sync_reg) begin
         res_reg <= '0;
         res_valid_reg <= 1'b0;
         psr_reg <= `CIS_PSR_RESET;
         sp_reg <= 32'h00000000;
         sb_reg <= 32'h00000000;
         fp_reg <= 32'h00000000;
         intb_reg <= 32'h00000000;
      end else begin
         res_reg <= res_next;
         res_valid_reg <= res_valid_next;
         psr_reg <= psr_next;
         sp_reg <= sp_next;
         sb_reg <= sb_next;
         fp_reg <= fp_next;
         intb_reg <= intb_next;
      end
   end

   assign res = res_reg;
   assign res_valid = res_valid_reg;
   assign proc_condition_reg = psr_reg;

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn_sync_reg);

   a_user_return_trap: assert property (
      req_valid && psr_reg[`CIS_PSR_U] && (req.op == OP_TRET || req.op == OP_IRET)
      |=> res_valid && res.trap_illegal && !res.ret && $stable(psr_reg))
      else $error("return in user mode did not trap");
   a_bitset_word_trap: assert property (
      req_valid && psr_reg[`CIS_PSR_U] && req.op == OP_BSET && req.len != LEN_B
      |=> res.trap_illegal && psr_reg == $past(psr_reg))
      else $error("word status set in user mode not trapped");
   a_bitset_byte_ok: assert property (
      req_valid && psr_reg[`CIS_PSR_U] && req.op == OP_BSET && req.len == LEN_B
      |=> !res.trap_illegal && psr_reg[7:0] == ($past(psr_reg[7:0]) | $past(req.src[7:0])))
      else $error("byte status set in user mode misbehaved");
   a_dedicated_load_sb: assert property (
      req_valid && req.op == OP_LDREG && req.areg == AR_SB && req.len == LEN_D
      |=> !res.trap_illegal && sb_reg == $past(req.src))
      else $error("static base load not unprivileged or not stored");
   a_quick_load_sext: assert property (
      req_valid && req.op == OP_QLOAD && req.len == LEN_D
      |=> res.value[31:4] == {28{res.value[3]}} && res.value[3:0] == $past(req.field_write_align[`CIS_SHORT_LSB +: 4]))
      else $error("quick load not sign extended");
   a_cond_bool_value: assert property (
      req_valid && req.op == OP_CBOOL && psr_reg[`CIS_PSR_Z] && req.field_write_align[`CIS_COND_LSB +: 4] == 4'h0
      |=> res.value == 32'h00000001)
      else $error("condition result not boolean one");
   a_string_limit_end: assert property (
      req_valid && req.op == OP_STRING && req.r0 == 32'h00000001 && !req.until_opt && !req.while_opt
      |=> res.done && res.r0 == 32'h00000000)
      else $error("string did not end at zero limit");
   a_string_backward: assert property (
      req_valid && req.op == OP_STRING && req.backward && req.r0 > 32'h00000001 &&
      !req.until_opt && !req.while_opt && req.len == LEN_B
      |=> res.r1 == $past(req.r1) - 32'h00000001 && !res.done)
      else $error("backward string pointer not decremented");
   a_loop_branch: assert property (
      req_valid && req.op == OP_ACB
      |=> res.branch == (res.value != 32'h00000000) &&
      res.value == fit($past(req.dst) + {{28{$past(req.field_write_align[`CIS_SHORT_LSB + 3])}},
      $past(req.field_write_align[`CIS_SHORT_LSB +: 4])}, $past(req.len)))
      else $error("loop branch disagrees with result");
   a_result_latency: assert property (
      req_valid |-> ##`CIS_LAT_CYCLES res_valid)
      else $error("result not one cycle after request");
endmodule // cis_exec

// ===== cis_regs.svh
// Constants for the instruction execution unit
`ifndef CIS_REGS_SVH
`define CIS_REGS_SVH
`define CIS_SHORT_LSB 7
`define CIS_COND_LSB 7
`define CIS_PSR_W 16
`define CIS_PSR_RESET 16'h0000
`define CIS_PSR_C 0
`define CIS_PSR_L 2
`define CIS_PSR_F 5
`define CIS_PSR_Z 6
`define CIS_PSR_N 7
`define CIS_PSR_U 8
`define CIS_LOW_BYTE_W 8
`define CIS_BLK_MIN 32'h00000001
`define CIS_BLK_MAX 32'h00000010
`define CIS_BLK_BYTES 16
`define CIS_SFLD_OFF_LSB 5
`define CIS_SFLD_LEN_W 5
`define CIS_LAT_CYCLES 1
`endif

// ===== cis_pkg.sv
// Types and shared helpers for the instruction execution unit
package cis_pkg;
   typedef enum logic [1:0] {LEN_B = 2'h0, LEN_W = 2'h1, LEN_D = 2'h3} cis_len_type;
   typedef enum logic [2:0] {AR_SP, AR_SB, AR_FP, AR_INTB, AR_PSR, AR_LOWB} cis_areg_type;
   typedef enum logic [5:0] {
      OP_MOVE, OP_QLOAD, OP_QSUM, OP_QCMP, OP_BCOPY, OP_BCMP, OP_ZEXT, OP_SEXT,
      OP_ADD, OP_CADD, OP_SUB, OP_BSUB, OP_CMP, OP_TZRAT, OP_TZRES, OP_FLRAT,
      OP_FLRES, OP_LSBINV, OP_ALLINV, OP_CBOOL, OP_LSH, OP_ASH, OP_ROT, OP_FREAD,
      OP_FWRITE, OP_SFREAD, OP_SFWRITE, OP_STRING, OP_ACB, OP_LDREG, OP_STREG,
      OP_BSET, OP_BCLR, OP_TRET, OP_IRET
   } cis_op_type;

   typedef struct packed {
      cis_op_type op;
      cis_len_type len;
      cis_len_type dst_len;
      cis_areg_type areg;
      logic [23:0] field_write_align;
      logic [31:0] src;
      logic [31:0] dst;
      logic [31:0] idx;
      logic [31:0] disp_raw;
      logic [63:0] tail;
      logic [2:0] ext_len;
      logic [31:0] pc;
      logic [127:0] blk_a;
      logic [127:0] blk_b;
      logic [31:0] r0;
      logic [31:0] r1;
      logic [31:0] r2;
      logic [31:0] r3;
      logic [31:0] r4;
      logic backward;
      logic until_opt;
      logic while_opt;
   } cis_req_type;

   typedef struct packed {
      logic [31:0] value;
      logic [127:0] blk;
      logic [31:0] r0;
      logic [31:0] r1;
      logic [31:0] r2;
      logic [31:0] aux;
      logic [31:0] target;
      logic branch;
      logic done;
      logic equal;
      logic trap_illegal;
      logic trap_div;
      logic ret;
   } cis_res_type;

   function automatic logic [5:0] len_width(cis_len_type l);
      case (l)
         LEN_B: len_width = 6'h08;
         LEN_W: len_width = 6'h10;
         default: len_width = 6'h20;
      endcase
   endfunction

   function automatic logic [31:0] fit(logic [31:0] v, cis_len_type l);
      case (l)
         LEN_B: fit = {24'h000000, v[7:0]};
         LEN_W: fit = {16'h0000, v[15:0]};
         default: fit = v;
      endcase
   endfunction

   function automatic logic [31:0] sext(logic [31:0] v, cis_len_type l);
      case (l)
         LEN_B: sext = {{24{v[7]}}, v[7:0]};
         LEN_W: sext = {{16{v[15]}}, v[15:0]};
         default: sext = v;
      endcase
   endfunction
endpackage

// ===== cis_bitops.sv
// Shifter, rotator and bit field unit
module cis_bitops (
   input cis_pkg::cis_op_type op,
   input cis_pkg::cis_len_type len,
   input logic [7:0] count,
   input logic [31:0] base,
   input logic [31:0] field_write_align,
   input logic [4:0] off,
   input logic [5:0] flen,
   output logic [31:0] y
);
   import cis_pkg::*;
   logic [7:0] w;
   logic [7:0] mag;
   logic [7:0] k;
   logic [31:0] v;
   logic [31:0] fmask;

   always_comb begin
      w = {2'b00, len_width(len)};
      mag = count[7] ? 8'(-count) : count;
      k = mag % w;
      v = fit(base, len);
      fmask = (flen >= 6'h20) ? 32'hFFFFFFFF : ((32'h00000001 << flen) - 32'h00000001);
      y = 32'h00000000;
      case (op)
         OP_LSH, OP_ASH: begin
            // Positive count moves left, negative moves right
            if (!count[7]) begin
               y = (mag >= w) ? 32'h00000000 : fit(v << mag, len);
            end else if (op == OP_LSH) begin
               y = (mag >= w) ? 32'h00000000 : (v >> mag);
            end else begin
               y = fit(32'($signed(sext(base, len)) >>> ((mag >= w) ? 8'h1F : mag)), len);
            end
         end
         OP_ROT: begin
            // Right rotation by k equals left rotation by width minus k
            if (count[7] && k != 8'h00) begin
               k = w - k;
            end
            y = fit((v << k) | (v >> (w - k)), len);
         end
         OP_FREAD, OP_SFREAD: begin
            y = (base >> off) & fmask;
         end
         OP_FWRITE, OP_SFWRITE: begin
            y = (base & ~(fmask << off)) | ((field_write_align & fmask) << off);
         end
         default: y = 32'h00000000;
      endcase
   end
endmodule // cis_bitops

// ===== tb_top.sv
// Self-checking bench for the instruction execution unit
`include "cis_regs.svh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import cis_pkg::*;
   logic clk, rstn, req_valid, res_valid;
   logic [15:0] proc_condition_reg;
   cis_req_type req, r;
   cis_res_type res;
   int fail_count, n_checks, ia, ib, q, m, qf, mf;
   logic [31:0] e, d;
   logic [127:0] eb;
   logic [32:0] s;
   logic [6:0] bn [7] = '{7'h00, 7'h01, 7'h10, 7'h11, 7'h05, 7'h0C, 7'h09};
   logic [7:0] cn [4] = '{8'h03, 8'hFD, 8'hE1, 8'h28};
   cis_op_type pop [7] = '{OP_TRET, OP_IRET, OP_BSET, OP_BCLR, OP_LDREG, OP_STREG, OP_LDREG};
   cis_len_type pln [7] = '{LEN_D, LEN_D, LEN_W, LEN_D, LEN_B, LEN_D, LEN_D};
   cis_areg_type par [7] = '{AR_SP, AR_SP, AR_SP, AR_SP, AR_PSR, AR_INTB, AR_INTB};
   cis_exec u_dut (.clk(clk), .rstn(rstn), .req_valid(req_valid), .req(req), .res_valid(res_valid),
      .res(res), .proc_condition_reg(proc_condition_reg));
   ////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      #100000;
      fail_count++;
      print_verdict();
   end
   task automatic chk(logic [127:0] seen, logic [127:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   function automatic logic [31:0] fitm(logic [31:0] v, cis_len_type l);
      return (l == LEN_B) ? (v & 32'h000000FF) : (l == LEN_W) ? (v & 32'h0000FFFF) : v;
   endfunction
   function automatic cis_req_type mk(cis_op_type o, cis_len_type l, logic [31:0] a, logic [31:0] t);
      mk = '0;
      mk.op = o;
      mk.len = l;
      mk.src = a;
      mk.dst = t;
   endfunction
   // Request is scrambled after its taking edge: the result must not follow it
   task automatic issue(cis_req_type x);
      @(posedge clk);
      req <= x;
      req_valid <= 1'b1;
      @(posedge clk);
      req_valid <= 1'b0;
      req <= ~x;
      #1;
      chk(res_valid, 1'b1);
   endtask
   task automatic rst();
      @(posedge clk);
      rstn <= 1'b0;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
   endtask
   task automatic str(cis_len_type l, logic bk, logic u, logic w, logic [31:0] c, logic mt);
      int sz;
      logic stop;
      r = mk(OP_STRING, l, fitm($urandom, l), 32'h0);
      r.r0 = c;
      r.r1 = $urandom;
      r.r2 = $urandom;
      r.r3 = $urandom;
      r.r4 = mt ? r.src : r.src ^ 32'h1;
      r.backward = bk;
      r.until_opt = u;
      r.while_opt = w;
      issue(r);
      stop = (c == 0) || (u && mt) || (w && !mt);
      sz = (l == LEN_B) ? 1 : (l == LEN_W) ? 2 : 4;
      sz = bk ? -sz : sz;
      chk(res.done, stop || c == 1);
      chk(res.r0, stop ? c : c - 1);
      chk(res.r1, 32'(stop ? r.r1 : r.r1 + sz));
      chk(res.r2, 32'(stop ? r.r2 : r.r2 + sz));
      chk(res.aux, 32'(r.r3 + r.src[7:0]));
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      rstn = 1'b0;
      req_valid = 1'b0;
      req = '0;
      void'($urandom(32'h97A8C9FC));
      rst();
      for (int i = 0; i < 3; i++) begin
         r = mk(OP_QLOAD, cis_len_type'(i == 2 ? 3 : i), $urandom, $urandom);
         r.field_write_align = 24'($urandom);
         e = {{28{r.field_write_align[10]}}, r.field_write_align[10:7]};
         issue(r);
         chk(res.value, fitm(e, r.len));
         r.op = OP_QSUM;
         issue(r);
         chk(res.value, fitm(r.dst + e, r.len));
         r.op = OP_ACB;
         if (i == 0) r.dst = -e;
         r.pc = $urandom;
         d = $urandom;
         r.disp_raw = {1'b0, d[6:0], 24'h000000};
         issue(r);
         chk(res.value, fitm(r.dst + e, r.len));
         chk(res.branch, fitm(r.dst + e, r.len) != 0);
         if (i != 0) chk(res.target, 32'(r.pc + {{25{d[6]}}, d[6:0]}));
      end
      for (int i = 0; i < 2; i++) begin
         r = mk(OP_ZEXT, LEN_B, $urandom, 32'h0);
         r.src[7] = (i == 0);
         r.dst = r.src;
         r.dst_len = i ? LEN_D : LEN_W;
         issue(r);
         chk(res.value, {24'h000000, r.src[7:0]});
         r.op = OP_SEXT;
         issue(r);
         chk(res.value, fitm({{24{r.src[7]}}, r.src[7:0]}, r.dst_len));
      end
      r = mk(OP_LSBINV, LEN_W, $urandom, 32'h0);
      r.dst = r.src;
      issue(r);
      chk(res.value, fitm(r.src ^ 32'h1, LEN_W));
      r.op = OP_ALLINV;
      issue(r);
      chk(res.value, fitm(~r.src, LEN_W));
      r = mk(OP_SFREAD, LEN_D, $urandom, $urandom);
      r.ext_len = 3'($urandom);
      r.tail = {$urandom, $urandom};
      d = {24'h000000, r.tail[{r.ext_len, 3'b000} +: 8]};
      s = (33'h1 << (d[4:0] + 1)) - 33'h1;
      issue(r);
      chk(res.value, 32'((r.src >> d[7:5]) & s[31:0]));
      r.op = OP_SFWRITE;
      issue(r);
      chk(res.value, 32'((r.dst & ~(s[31:0] << d[7:5])) | ((r.src & s[31:0]) << d[7:5])));
      for (int k = 0; k < 4; k++) begin
         ia = $urandom;
         ib = (k == 0) ? 0 : int'($urandom % 2001) - 1000;
         if (k > 0 && ib == 0) ib = 3;
         q = (ib == 0) ? 0 : ia / ib;
         m = (ib == 0) ? 0 : ia % ib;
         qf = (m != 0 && ((m < 0) != (ib < 0))) ? q - 1 : q;
         mf = (qf != q) ? m + ib : m;
         for (int j = 0; j < 4; j++) begin
            issue(mk(cis_op_type'(int'(OP_TZRAT) + j), LEN_D, ib, ia));
            e = (j == 0) ? q : (j == 1) ? m : (j == 2) ? qf : mf;
            chk(res.value, e);
            chk(res.trap_div, ib == 0);
         end
      end
      for (int k = 0; k < 12; k++) begin
         d = {{24{cn[k % 4][7]}}, cn[k % 4]};
         r = mk(k < 4 ? OP_LSH : k < 8 ? OP_ASH : OP_ROT, LEN_D, d, $urandom | 32'h80000000);
         issue(r);
         e = r.dst;
         if (k >= 8) begin
            repeat ((int'($signed(cn[k % 4])) % 32 + 32) % 32) e = {e[30:0], e[31]};
         end else if (!d[31]) e = r.dst << d;
         else if (k < 4) e = r.dst >> -d;
         else e = $signed(r.dst) >>> -d;
         chk(res.value, e);
      end
      for (int k = 0; k < 7; k++) begin
         r = mk(OP_BCOPY, LEN_B, 32'h0, 32'h0);
         r.disp_raw = (k % 3 == 0) ? {1'b0, bn[k], 24'h000000} :
            (k % 3 == 1) ? {2'b10, 7'h00, bn[k], 16'h0000} : {2'b11, 23'h000000, bn[k]};
         r.blk_a = {$urandom, $urandom, $urandom, $urandom};
         r.blk_b = {$urandom, $urandom, $urandom, $urandom};
         issue(r);
         for (int i = 0; i < 16; i++) eb[8*i +: 8] = (i < bn[k]) ? r.blk_a[8*i +: 8] : r.blk_b[8*i +: 8];
         chk(res.trap_illegal, bn[k] < 1 || bn[k] > 16);
         if (bn[k] >= 1 && bn[k] <= 16) chk(res.blk, eb);
         r.op = OP_BCMP;
         r.blk_b = (k % 2 == 1) ? eb : eb ^ 128'h1;
         issue(r);
         chk(res.equal, bn[k] >= 1 && bn[k] <= 16 && k % 2 == 1);
         if (bn[k] >= 1 && bn[k] <= 16) chk(proc_condition_reg[`CIS_PSR_Z], k % 2 == 1);
      end
      str(LEN_B, 1'b0, 1'b1, 1'b0, 32'h5, 1'b1);
      str(LEN_B, 1'b0, 1'b0, 1'b1, 32'h5, 1'b0);
      str(LEN_W, 1'b0, 1'b0, 1'b0, 32'h0, 1'b0);
      str(LEN_W, 1'b1, 1'b0, 1'b0, 32'h1, 1'b0);
      str(LEN_D, 1'b0, 1'b1, 1'b0, 32'h4, 1'b0);
      str(LEN_B, 1'b1, 1'b0, 1'b0, 32'h3, 1'b0);
      for (int j = 0; j < 2; j++) begin
         d = $urandom;
         issue(mk(OP_CMP, LEN_D, d, j ? d : ~d));
         chk(proc_condition_reg[`CIS_PSR_Z], j);
         issue(mk(OP_CBOOL, LEN_W, 32'h0, 32'h0));
         chk(res.value, j);
      end
      issue(mk(OP_ADD, LEN_D, 32'h00000001, 32'hFFFFFFFF));
      chk(res.value, 32'h0);
      chk(proc_condition_reg[`CIS_PSR_C], 1'b1);
      r = mk(OP_CADD, LEN_D, $urandom, $urandom);
      issue(r);
      s = r.dst + r.src + 33'h1;
      chk(res.value, s[31:0]);
      r = mk(OP_BSUB, LEN_D, $urandom, $urandom);
      issue(r);
      chk(res.value, 32'(r.dst - r.src - s[32]));
      r = mk(OP_LDREG, LEN_D, 32'h00000100, 32'h0);
      r.areg = AR_PSR;
      issue(r);
      chk(proc_condition_reg, 16'h0100);
      for (int k = 0; k < 7; k++) begin
         r = mk(pop[k], pln[k], 32'h000000FF, 32'h0);
         r.areg = par[k];
         issue(r);
         chk(res.trap_illegal, 1'b1);
         chk(proc_condition_reg, 16'h0100);
      end
      issue(mk(OP_BSET, LEN_B, 32'h00000001, 32'h0));
      chk(res.trap_illegal, 1'b0);
      chk(proc_condition_reg, 16'h0101);
      r = mk(OP_LDREG, LEN_D, $urandom, 32'h0);
      for (int k = 0; k < 2; k++) begin
         r.areg = k ? AR_SB : AR_FP;
         issue(r);
         chk(res.trap_illegal, 1'b0);
      end
      r.op = OP_STREG;
      issue(r);
      chk(res.value, r.src);
      rst();
      chk(proc_condition_reg, 16'h0000);
      print_verdict();
   end
endmodule // tb_top
